// [hw/cbu_defs.vh]
// Constants of the conditional branch unit
`ifndef CBU_DEFS_VH
`define CBU_DEFS_VH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define CBU_PC_W 13
`define CBU_OFS_W 7
`define CBU_INSN_W 16

// ----------------------------------------------------------------
// Instruction encoding: 1111 0s kkkkkkk bbb
// ----------------------------------------------------------------
`define CBU_GRP_MASK 16'hF800
`define CBU_GRP_CODE 16'hF000
`define CBU_POL_BIT 10
`define CBU_OFS_LSB 3
`define CBU_OFS_MSB 9
`define CBU_IDX_MSB 2

// ----------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------
`define CBU_FLAG_C 3'h0
`define CBU_FLAG_Z 3'h1

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define CBU_PC_RESET 13'h0000
`define CBU_CYC_NOT_TAKEN 1
`define CBU_CYC_TAKEN 2

`endif

// [hw/cbu_branch_unit.v]
// Conditional relative branch unit of an 8-bit core
`timescale 1ns/1ps
`default_nettype none
`include "cbu_defs.vh"

module cbu_branch_unit (
    input wire sys_clk,
    input wire srst,
    input wire insn_valid,
    input wire [15:0] insn_word,
    input wire [12:0] insn_pc,
    input wire [7:0] status_register,
    output wire insn_ready,
    output reg done_reg,
    output reg taken_reg,
    output reg pc_load_reg,
    output reg [12:0] pc_target_reg,
    output reg is_branch_reg,
    output wire flags_write
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function is_group;
        input [15:0] w;
        begin
            is_group = ((w & `CBU_GRP_MASK) == `CBU_GRP_CODE);
        end
    endfunction

    // Equal/not-equal and carry forms are the generic forms with fixed
    // indices, so one test covers all six.
    function cond_met;
        input [15:0] w;
        input [7:0] sr;
        begin
            if (w[`CBU_POL_BIT])
                cond_met = ~sr[w[`CBU_IDX_MSB:0]];
            else
                cond_met = sr[w[`CBU_IDX_MSB:0]];
        end
    endfunction

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_FLUSH = 2'b10;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    wire accept;
    wire hit;
    wire met;
    wire take;
    wire in_flush;
    wire [6:0] ofs;
    wire [12:0] ofs_ext;
    wire [12:0] next_pc;
    wire [12:0] target;

    // ----------------------------------------------------------------
    // Handshake and decode
    // ----------------------------------------------------------------
    assign insn_ready = state_reg[0];
    assign in_flush = state_reg[1];
    assign accept = insn_valid & insn_ready;
    assign hit = is_group(insn_word);
    assign met = cond_met(insn_word, status_register);
    assign take = hit & met;
    assign ofs = insn_word[`CBU_OFS_MSB:`CBU_OFS_LSB];

    // ----------------------------------------------------------------
    // Offset sign extension
    // ----------------------------------------------------------------
    // Word offsets reach 63 forward and 64 back; a longer jump
    // needs another instruction.
    assign ofs_ext[`CBU_OFS_W-1:0] = ofs;
    genvar gi;
    generate
        for (gi = `CBU_OFS_W; gi < `CBU_PC_W; gi = gi + 1)
        begin : g_sext
            assign ofs_ext[gi] = ofs[`CBU_OFS_W-1];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Target and flags
    // ----------------------------------------------------------------
    // Sum wraps modulo the program counter width
    assign next_pc = insn_pc + 13'h0001;
    assign target = next_pc + ofs_ext;
    // Branches never touch the status register
    assign flags_write = 1'b0;

    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (accept && hit && met)
                    state_next = ST_FLUSH;
            end
            ST_FLUSH:
            begin
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_reg <= ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // Result registers
    // ----------------------------------------------------------------
    // A taken branch spends its second cycle refusing fetch, which
    // stands in for the pipeline flush of the discarded word.
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            done_reg <= 1'b0;
        end
        else if (accept)
        begin
            done_reg <= hit & ~met;
        end
        else if (in_flush)
        begin
            done_reg <= 1'b1;
        end
        else
        begin
            done_reg <= 1'b0;
        end
    end

    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            taken_reg <= 1'b0;
        end
        else if (accept)
        begin
            taken_reg <= take;
        end
    end

    // Load is a single pulse; the flush cycle never repeats it
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            pc_load_reg <= 1'b0;
        end
        else if (accept)
        begin
            pc_load_reg <= take;
        end
        else
        begin
            pc_load_reg <= 1'b0;
        end
    end

    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            pc_target_reg <= `CBU_PC_RESET;
        end
        else if (accept && take)
        begin
            pc_target_reg <= target;
        end
    end

    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            is_branch_reg <= 1'b0;
        end
        else if (accept)
        begin
            is_branch_reg <= hit;
        end
    end

endmodule // cbu_branch_unit
`default_nettype wire

// [tb/cbu_flag_model.sv]
// Status register model beside the branch unit
`timescale 1ns/1ps
`default_nettype none
module cbu_flag_model (input wire logic sys_clk,
    input wire logic [7:0] flags_in, output var logic [7:0] status_register);
    always @(posedge sys_clk) status_register <= flags_in;
endmodule // cbu_flag_model
`default_nettype wire

// [tb/cbu_props_properties.sv]
// Port assertions of the branch unit
`timescale 1ns/1ps
`default_nettype none
module cbu_props (input wire logic sys_clk, srst, insn_valid, insn_ready,
    done_reg, taken_reg, pc_load_reg, is_branch_reg, flags_write,
    input wire logic [15:0] insn_word, input wire logic [12:0] insn_pc,
    pc_target_reg, input wire logic [7:0] status_register);
    wire a = insn_valid & insn_ready & insn_word[15:11] == 5'h1e;
    wire s = insn_word[10], t = status_register[insn_word[2:0]] ^ s;
    wire z = a & insn_word[2:0] == 3'h1, c = a & insn_word[2:0] == 3'h0;
    logic [12:0] tg;
    always @(posedge sys_clk) tg <= insn_pc + {{6{insn_word[9]}},
        insn_word[9:3]} + 13'h1;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    a_taken_pair: assert property (
        a & t |=> pc_load_reg & !insn_ready ##1 done_reg) else $error("tk");
    a_zero_eq: assert property (
        z & !s |=> taken_reg == $past(status_register[1])) else $error("eq");
    a_zero_ne: assert property (
        z & s |=> taken_reg != $past(status_register[1])) else $error("ne");
    a_carry_set: assert property (
        c & !s |=> taken_reg == $past(status_register[0])) else $error("cs");
    a_carry_clr: assert property (
        c & s |=> taken_reg != $past(status_register[0])) else $error("cc");
    a_fall_one: assert property (
        a & !t |=> done_reg & !pc_load_reg) else $error("nt");
    a_no_flags: assert property (!flags_write) else $error("fw");
    a_target_sum: assert property (
        pc_load_reg |-> pc_target_reg == tg) else $error("tg");
    c_taken: cover property (pc_load_reg);
    c_fall: cover property (done_reg & !taken_reg);
    c_other: cover property (insn_valid & !insn_word[15]);
    c_refused: cover property (insn_valid & !insn_ready);
endmodule // cbu_props
bind cbu_branch_unit cbu_props u_props (.*);
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench of the branch unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'h0, srst = 1'h1, insn_valid = 1'h0, insn_ready, done_reg;
    logic taken_reg, pc_load_reg, is_branch_reg, flags_write;
    logic [15:0] insn_word = 16'h0000;
    logic [12:0] insn_pc = 13'h0000, pc_target_reg;
    logic [7:0] flags_in = 8'h00, status_register;
    int mismatches = 0, comparisons = 0, i;
    // Clear bit, offset, index, pc, flags, taken
    logic [32:0] rows [6] = '{{1'h0, 7'h05, 3'h5, 13'h0100, 8'h20, 1'h1},
        {1'h1, 7'h7f, 3'h7, 13'h0100, 8'h80, 1'h0},
        {1'h0, 7'h40, 3'h1, 13'h0040, 8'h02, 1'h1},
        {1'h1, 7'h3f, 3'h1, 13'h0010, 8'h02, 1'h0},
        {1'h0, 7'h3f, 3'h0, 13'h1fff, 8'h01, 1'h1},
        {1'h1, 7'h7f, 3'h0, 13'h0100, 8'hfe, 1'h1}};
    cbu_flag_model model_u (.*);
    cbu_branch_unit dut_u (
        .sys_clk(sys_clk),
        .srst(srst),
        .insn_valid(insn_valid),
        .insn_word(insn_word),
        .insn_pc(insn_pc),
        .status_register(status_register),
        .insn_ready(insn_ready),
        .done_reg(done_reg),
        .taken_reg(taken_reg),
        .pc_load_reg(pc_load_reg),
        .pc_target_reg(pc_target_reg),
        .is_branch_reg(is_branch_reg),
        .flags_write(flags_write)
    );
    initial forever #5 sys_clk = ~sys_clk;
    // About 54 cycles of tests; nearly four times that is a hang
    initial #2000 end_sim(1);
    task chk(input logic [12:0] got, exp);
        comparisons++;
        if (got !== exp) mismatches++;
        if (got !== exp) $display("unexpected at %0t: %h not %h", $time, got, exp);
    endtask
    task op(input logic [15:0] w, input logic [12:0] pc, input logic [7:0] f,
        input logic e);
        // Flags settle one edge ahead, as the core would have them
        @(negedge sys_clk) flags_in = f;
        @(negedge sys_clk) {insn_word, insn_pc, insn_valid} = {w, pc, 1'h1};
        @(negedge sys_clk) insn_valid = 1'h0;
        chk({pc_load_reg, taken_reg, insn_ready}, {e, e, !e});
        chk(done_reg, !e & w[15:11] == 5'h1e);
        chk(is_branch_reg, w[15:11] == 5'h1e);
        if (e) chk(pc_target_reg, pc + {{6{w[9]}}, w[9:3]} + 13'h1);
        @(negedge sys_clk) chk(done_reg, e);
    endtask
    task end_sim(input int late);
        mismatches += late;
        $display("mismatches %0d of %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(negedge sys_clk);
        chk({pc_load_reg, done_reg, taken_reg, is_branch_reg}, 13'h0);
        chk({flags_write, insn_ready}, 13'h0001);
        chk(pc_target_reg, 13'h0000);
        srst = 1'h0;
        for (i = 0; i < 6; i++) op({5'h1e, rows[i][32:22]}, rows[i][21:9],
            rows[i][8:1], rows[i][0]);
        op(16'h1234, 13'h0000, 8'hff, 1'h0);
        // Offer held through the refused flush cycle, then reset mid-flush
        @(negedge sys_clk);
        flags_in = 8'h02;
        @(negedge sys_clk);
        insn_word = 16'hf009;
        insn_pc = 13'h0020;
        insn_valid = 1'h1;
        @(negedge sys_clk);
        chk({pc_load_reg, insn_ready}, 13'h0002);
        chk(pc_target_reg, 13'h0022);
        @(negedge sys_clk);
        chk({pc_load_reg, done_reg, taken_reg}, 13'h0003);
        @(negedge sys_clk);
        chk({pc_load_reg, insn_ready}, 13'h0002);
        srst = 1'h1;
        insn_valid = 1'h0;
        @(negedge sys_clk);
        chk({pc_load_reg, done_reg, taken_reg, insn_ready}, 13'h1);
        srst = 1'h0;
        end_sim(0);
    end
endmodule // tb_top
`default_nettype wire
